// [hw/sram_host.sv]
// host controller that runs read, write and read-write cycles on the latched static ram
`timescale 1ns/1ns
module sram_host
	import sram_host_pkg::*;
(
	input wire logic clk_in, // 10 MHz clock
	input wire logic resetn_in, // synchronous reset, active low
	input wire logic strap_in, // variant select level for the strap pin
	input wire logic retain_in, // hold memory in data retention
	input wire logic power_good_in, // supply at operating level
	input wire sram_host_pkg::req_type req_in, // request: command, address, data
	input wire logic req_valid_in, // request offered
	output logic req_ready_out, // request taken this cycle
	output logic [sram_host_pkg::DATA_W-1:0] rdata_out, // read data
	output logic rdata_valid_out, // read data pulse
	output logic done_out, // cycle finished pulse
	output sram_host_pkg::pins_type pins_out, // pins toward memory
	input wire logic [sram_host_pkg::DATA_W-1:0] dq_in // data pins from memory
);
	import sram_host_pkg::*;

	// ********************************************************
	// state
	// ********************************************************
	typedef enum logic [2:0] {
		ST_RECOVER,
		ST_IDLE,
		ST_SETUP,
		ST_HOLD,
		ST_READ,
		ST_WRITE,
		ST_HIGH
	} state_type;

	state_type state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	req_type req_reg, req_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic done_reg, done_next;
	pins_type pins_reg, pins_next;

	// ready must also drop on lost supply, or idle would leave with a request taken
	assign req_ready_out = (state_reg == ST_IDLE) && !retain_in && power_good_in;
	assign rdata_out = rdata_reg;
	assign rdata_valid_out = rvalid_reg;
	assign done_out = done_reg;
	assign pins_out = pins_reg;

	// ********************************************************
	// sequencer
	// ********************************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		req_next = req_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		done_next = 1'b0;
		pins_next = pins_reg;
		pins_next.strap = strap_in;
		case (state_reg)
			ST_RECOVER: begin
				// chip enable and output enable held high, bus released
				pins_next.chip_en_n = 1'b1;
				pins_next.out_en_n = 1'b1;
				pins_next.wr_en_n = 1'b1;
				pins_next.dq_oe_n = 1'b1;
				if (!power_good_in || retain_in) begin
					cnt_next = '0;
				end else if (cnt_reg >= CNT_W'(MIN_HIGH_TIM_CYC - 1)) begin
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_IDLE: begin
				if (retain_in || !power_good_in) begin
					cnt_next = '0;
					state_next = ST_RECOVER;
				end else if (req_valid_in) begin
					req_next = req_in;
					pins_next.addr = req_in.addr;
					cnt_next = '0;
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// address stood one setup time; now drop chip enable
				if (cnt_reg >= CNT_W'(ADDR_SETUP_CYC - 1)) begin
					pins_next.chip_en_n = 1'b0;
					// pure write: write enable low with ce, output enable stays high
					if (req_reg.cmd == CMD_WRITE) begin
						pins_next.wr_en_n = 1'b0;
						pins_next.dq = req_reg.wdata;
						pins_next.dq_oe_n = 1'b0;
					end
					cnt_next = '0;
					state_next = ST_HOLD;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_HOLD: begin
				if (cnt_reg >= CNT_W'(ADDR_HOLD_CYC - 1)) begin
					cnt_next = '0;
					if (req_reg.cmd == CMD_WRITE) begin
						state_next = ST_WRITE;
					end else begin
						pins_next.out_en_n = 1'b0;
						state_next = ST_READ;
					end
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_READ: begin
				if (cnt_reg >= CNT_W'(ACCESS_CYC - 1)) begin
					rdata_next = dq_in;
					rvalid_next = 1'b1;
					cnt_next = '0;
					if (req_reg.cmd == CMD_READ_WRITE) begin
						// stop the memory driving in the same cycle that ours goes on
						pins_next.out_en_n = 1'b1;
						pins_next.wr_en_n = 1'b0;
						pins_next.dq = req_reg.wdata;
						pins_next.dq_oe_n = 1'b0;
						state_next = ST_WRITE;
					end else begin
						pins_next.chip_en_n = 1'b1;
						pins_next.out_en_n = 1'b1;
						state_next = ST_HIGH;
					end
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_WRITE: begin
				// ce rises with write enable still low, so ce commits the data
				if (cnt_reg >= CNT_W'(CE_LOW_CYC - 1) &&
				    cnt_reg >= CNT_W'(MIN_WR_PULS_CYC - 1) &&
				    cnt_reg >= CNT_W'(DATA_SETUP_CYC - 1)) begin
					pins_next.chip_en_n = 1'b1;
					cnt_next = '0;
					state_next = ST_HIGH;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_HIGH: begin
				// data held one cycle past ce rise, then released
				pins_next.wr_en_n = 1'b1;
				pins_next.dq_oe_n = 1'b1;
				if (cnt_reg >= CNT_W'(MIN_HIGH_TIM_CYC - 1)) begin
					done_next = 1'b1;
					cnt_next = '0;
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			default: begin
				state_next = ST_RECOVER;
				cnt_next = '0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_reg <= ST_RECOVER;
			cnt_reg <= '0;
			req_reg <= '0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
			done_reg <= 1'b0;
			pins_reg <= '{chip_en_n: 1'b1, wr_en_n: 1'b1, out_en_n: 1'b1, strap: 1'b0,
				addr: '0, dq: '0, dq_oe_n: 1'b1};
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			req_reg <= req_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			done_reg <= done_next;
			pins_reg <= pins_next;
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	logic [CNT_W-1:0] high_cnt_reg;
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			high_cnt_reg <= '0;
		end else if (pins_reg.chip_en_n) begin
			high_cnt_reg <= (high_cnt_reg == '1) ? high_cnt_reg : high_cnt_reg + 1'b1;
		end else begin
			high_cnt_reg <= '0;
		end
	end

	ce_high_time_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$fell(pins_reg.chip_en_n) |-> high_cnt_reg >= CNT_W'(MIN_HIGH_TIM_CYC))
		else $error("chip enable high time too short");
	addr_stable_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$fell(pins_reg.chip_en_n) |-> $stable(pins_reg.addr) ##1 $stable(pins_reg.addr))
		else $error("address moved around chip enable fall");
	no_collide_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		!(pins_reg.dq_oe_n == 1'b0 && pins_reg.out_en_n == 1'b0 && !pins_reg.chip_en_n))
		else $error("host drives bus while memory output enabled");
	read_we_high_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		!pins_reg.out_en_n |-> pins_reg.wr_en_n)
		else $error("write enable low during read");
	write_oe_high_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		!pins_reg.wr_en_n |-> pins_reg.out_en_n)
		else $error("output enable low during write");
	ce_commit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$rose(pins_reg.chip_en_n) && !pins_reg.wr_en_n |-> $stable(pins_reg.dq) && !pins_reg.dq_oe_n)
		else $error("write data not held at chip enable rise");
	wr_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$fell(pins_reg.wr_en_n) |-> !pins_reg.wr_en_n [*2])
		else $error("write pulse too short");
	retain_ce_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		retain_in && state_reg == ST_RECOVER |=> pins_reg.chip_en_n && pins_reg.out_en_n)
		else $error("enables not high in retention");
endmodule

// [hw/sram_host_pkg.sv]
// package: pin bundles, commands and timing counts for the latched static ram host
package sram_host_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int DEPTH = 1024;
	localparam int CLK_PERIOD_NS = 100;
	// pin timings in ns
	localparam int ADDR_SETUP_NS = 10;
	localparam int ADDR_HOLD_NS = 50;
	localparam int CE_LOW_NS = 240;
	localparam int MIN_HIGH_TIM_NS = 150;
	localparam int MIN_WR_PULS_NS = 100;
	localparam int ACCESS_NS = 250;
	localparam int DATA_SETUP_NS = 100;
	// least times round up to whole cycles, so a zero time gives zero cycles; access time gets one cycle more
	localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CE_LOW_CYC = (CE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_HIGH_TIM_CYC = (MIN_HIGH_TIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_WR_PULS_CYC = (MIN_WR_PULS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;

	typedef enum logic [1:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_READ_WRITE
	} cmd_type;

	typedef struct packed {
		cmd_type cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_type;

	// pins driven toward the memory
	typedef struct packed {
		logic chip_en_n;
		logic wr_en_n;
		logic out_en_n;
		logic strap;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe_n;
	} pins_type;
endpackage

// [dv/sram_model.sv]
// behavioural model of the latched 1k x 8 static ram seen from the host pins
`timescale 1ns/1ns
module sram_model
	import sram_host_pkg::*;
(
	input wire sram_host_pkg::pins_type pins_in, // pins from the host
	output logic [sram_host_pkg::DATA_W-1:0] dq_out, // data pins toward the host
	output int viol_out // host faults seen on the pins
);
	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] lat;
	logic [DATA_W-1:0] last;
	logic drv;
	logic acc;
	realtime t_rise;
	initial begin
		viol_out = 0;
		last = 8'h00;
		acc = 1'b0;
		t_rise = -1000.0;
	end
	// address is taken only at the fall, so later address changes cannot move the cycle
	always @(negedge pins_in.chip_en_n) begin
		lat = pins_in.addr;
		acc = 1'b0;
		acc <= #(ACCESS_NS) 1'b1;
		if ($realtime - t_rise < MIN_HIGH_TIM_NS) viol_out++;
	end
	always @(posedge pins_in.chip_en_n) begin
		t_rise = $realtime;
		acc = 1'b0;
		if (!pins_in.wr_en_n) mem[lat] = pins_in.dq;
	end
	always @(posedge pins_in.wr_en_n)
		if (!pins_in.chip_en_n) mem[lat] = pins_in.dq;
	assign drv = !pins_in.chip_en_n && !pins_in.out_en_n && pins_in.wr_en_n;
	// before access time or when floating, show the inverse of the last byte
	assign dq_out = (drv && acc) ? mem[lat] : ~last;
	always @(negedge drv) last = mem[lat];
	always @(pins_in) #1 if (drv && !pins_in.dq_oe_n) viol_out++;
	always @(pins_in.strap) if ($realtime > 1000) viol_out++;
endmodule

// [dv/tb_sram_host.sv]
// self-checking bench for the latched static ram host with a reference memory
`timescale 1ns/1ns
module tb_sram_host;
	import sram_host_pkg::*;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic strap_in = 1'b1;
	logic retain_in = 1'b0;
	logic power_good_in = 1'b1;
	req_type req_in = '0;
	logic req_valid_in = 1'b0;
	logic req_ready_out, rdata_valid_out, done_out;
	logic [DATA_W-1:0] rdata_out, m_dq, dq_in;
	pins_type pins_out;
	int viol, i, r, mismatches = 0, cmp_count = 0, seed = 13;
	int ref_mem [DEPTH];
	logic [ADDR_W-1:0] q [$];
	always #50 clk_in = ~clk_in;
	assign dq_in = pins_out.dq_oe_n ? m_dq : pins_out.dq;
	sram_host i_sram_host (.clk_in(clk_in), .resetn_in(resetn_in), .strap_in(strap_in),
		.retain_in(retain_in), .power_good_in(power_good_in), .req_in(req_in),
		.req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .rdata_out(rdata_out),
		.rdata_valid_out(rdata_valid_out), .done_out(done_out), .pins_out(pins_out),
		.dq_in(dq_in));
	sram_model i_sram_model (.pins_in(pins_out), .dq_out(m_dq), .viol_out(viol));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	// entered at a falling edge; returns at the falling edge where done shows,
	// so the next call offers its request back to back
	task automatic xfer(input cmd_type c, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		int n;
		logic seen;
		logic [DATA_W-1:0] got;
		req_in = '{cmd: c, addr: ad, wdata: d};
		req_valid_in = 1'b1;
		n = 0;
		while (req_ready_out !== 1'b1) begin
			@(negedge clk_in);
			n++;
			if (n > 40) begin
				chk("ready wait", 1, 0);
				stop_test();
			end
		end
		@(negedge clk_in);
		req_valid_in = 1'b0;
		seen = 1'b0;
		got = 8'h00;
		n = 0;
		while (done_out !== 1'b1) begin
			if (rdata_valid_out === 1'b1) begin
				seen = 1'b1;
				got = rdata_out;
			end
			@(negedge clk_in);
			n++;
			if (n > 40) begin
				chk("done wait", 1, 0);
				stop_test();
			end
		end
		if (c != CMD_WRITE) begin
			chk("read pulse", 1, seen);
			chk($sformatf("rdata at %0h", ad), ref_mem[ad], got);
		end
		if (c != CMD_READ) ref_mem[ad] = d;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		resetn_in = 1'b1;
		chk("ce after reset", 1, pins_out.chip_en_n);
		chk("ready in recovery", 0, req_ready_out);
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			q.push_back((i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : r[ADDR_W-1:0]);
			r = $random(seed);
			xfer(CMD_WRITE, q[i], r[DATA_W-1:0]);
		end
		for (i = 23; i >= 0; i--) xfer(CMD_READ, q[i], 8'h00);
		for (i = 0; i < 6; i++) begin
			r = $random(seed);
			xfer(CMD_READ_WRITE, q[i], r[DATA_W-1:0]);
			xfer(CMD_READ, q[i], 8'h00);
		end
		// strap is copied only after the first edge past reset, so look now
		chk("strap", strap_in, pins_out.strap);
		// supply drops while idle: ready has to fall at once
		power_good_in = 1'b0;
		#1;
		chk("ready power low", 0, req_ready_out);
		@(negedge clk_in);
		power_good_in = 1'b1;
		retain_in = 1'b1;
		repeat (6) begin
			@(negedge clk_in);
			chk("ready in retention", 0, req_ready_out);
			chk("ce in retention", 1, pins_out.chip_en_n);
			chk("oe in retention", 1, pins_out.out_en_n);
		end
		retain_in = 1'b0;
		@(negedge clk_in);
		chk("ready power recovery", 0, req_ready_out);
		xfer(CMD_READ, q[0], 8'h00);
		chk("host pin faults", 0, viol);
		stop_test();
	end
endmodule
